/* common/arfr_pkg.sv */
// Purpose: Shared constants for the converter result formatting block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Register offsets are byte addresses.
package arfr_pkg;
	localparam int          RES_W          = 10;
	localparam int          BYTE_W         = 8;
	localparam int          ADDR_W         = 12;
	localparam int          CONV_CYC       = 16;
	// Register byte offsets.
	localparam logic [11:0] OFS_CTRL0      = 12'h000;
	localparam logic [11:0] OFS_CTRL1      = 12'h004;
	localparam logic [11:0] OFS_CTRL2      = 12'h008;
	localparam logic [11:0] OFS_RES_HIGH   = 12'h00c;
	localparam logic [11:0] OFS_RES_LOW    = 12'h010;
	localparam logic [11:0] OFS_IRQ_STAT   = 12'h014;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h018;
	localparam logic [11:0] OFS_ACQ_CNT    = 12'h01c;
	// Control register 0 fields.
	localparam int          BIT_ON         = 0;
	localparam int          BIT_GO         = 1;
	localparam int          CHS_LSB        = 2;
	localparam int          CHS_W          = 5;
	// Control register 1 fields; writable-bit masks of control registers 0 to 2.
	localparam int          BIT_JUSTIFY    = 7;
	localparam logic [7:0]  CTRL0_MASK     = 8'h7f;
	localparam logic [7:0]  CTRL1_MASK     = 8'hf3;
	localparam logic [7:0]  CTRL2_MASK     = 8'hf0;
	// Interrupt status bits; acquisition counter reset value.
	localparam int          IRQ_W          = 2;
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_EARLY      = 1;
	localparam logic [15:0] ACQ_CNT_RESET  = 16'h0000;
	// Converter sequencer states, one-hot.
	typedef enum logic [1:0] {
		ARFR_IDLE = 2'b01,
		ARFR_CONV = 2'b10
	} arfr_state_t;
endpackage : arfr_pkg

/* common/arfr_res_if.sv */
// Purpose: Carries a finished result from the sequencer to the result store.
// Assumes: Single clock domain.
// Notes: Load is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface arfr_res_if;
	logic                        load;
	logic [arfr_pkg::RES_W-1:0]  value;
	logic                        justify;
	logic                        sw_wr_high;
	logic                        sw_wr_low;
	logic [arfr_pkg::BYTE_W-1:0] sw_data;
	logic [arfr_pkg::BYTE_W-1:0] high_byte;
	logic [arfr_pkg::BYTE_W-1:0] low_byte;
	modport ctrl  (output load, value, justify, sw_wr_high, sw_wr_low, sw_data,
		input high_byte, low_byte);
	modport store (input load, value, justify, sw_wr_high, sw_wr_low, sw_data,
		output high_byte, low_byte);
endinterface : arfr_res_if
`default_nettype wire

/* hdl/arfr_result_store.sv */
// Purpose: Holds the two result bytes and formats each loaded result.
// Assumes: Result bytes have no reset; their power-on content is undefined.
// Notes: A load updates both bytes on the same edge; a software write moves one byte.
`timescale 1ns/1ps
`default_nettype none
module arfr_result_store (
	input  wire logic  pclk,
	input  wire logic  ce,
	arfr_res_if.store  res
);
	logic [arfr_pkg::BYTE_W-1:0] high_reg;
	logic [arfr_pkg::BYTE_W-1:0] low_reg;
	logic [arfr_pkg::BYTE_W-1:0] high_fmt;
	logic [arfr_pkg::BYTE_W-1:0] low_fmt;

	// Format the result; right justify pads high byte, left pads low byte.
	assign high_fmt = res.justify ? {6'h00, res.value[9:8]}
		: res.value[9:2];
	assign low_fmt  = res.justify ? res.value[7:0]
		: {res.value[1:0], 6'h00};

	// No reset on purpose: contents survive every reset except power-on.
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (res.load) begin
				high_reg <= high_fmt;
				low_reg  <= low_fmt;
			end else begin
				if (res.sw_wr_high) high_reg <= res.sw_data;
				if (res.sw_wr_low)  low_reg  <= res.sw_data;
			end
		end
	end

	assign res.high_byte = high_reg;
	assign res.low_byte  = low_reg;
endmodule : arfr_result_store
`default_nettype wire

/* hdl/arfr_top.sv */
// Purpose: Result formatting and register side of a 10-bit converter.
// Assumes: APB slave, 100 MHz pclk, conversion result arrives from the analog core.
`timescale 1ns/1ps
`default_nettype none
module arfr_top #(
	parameter int CONV_CYCLES = arfr_pkg::CONV_CYC
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              ce,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [arfr_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic [arfr_pkg::RES_W-1:0]        conversion_result,
	input  wire logic                              auto_trigger,
	output logic                                   converter_on,
	output logic      [arfr_pkg::CHS_W-1:0]        input_channel_sel,
	output logic                                   irq
);
	arfr_res_if res ();

	logic [7:0]                 ctrl0_reg;
	logic [7:0]                 ctrl1_reg;
	logic [7:0]                 ctrl2_reg;
	logic [7:0]                 ctrl0_wr;
	logic [arfr_pkg::IRQ_W-1:0] stat_reg;
	logic [arfr_pkg::IRQ_W-1:0] mask_reg;
	logic [15:0]                acq_reg;
	logic [15:0]                acq_next;
	logic [15:0]                cnt_reg;
	logic [15:0]                cnt_next;
	logic [arfr_pkg::RES_W-1:0] res_reg;
	logic                       load_reg;
	logic                       trig_s1_reg;
	logic                       trig_s2_reg;
	logic                       trig_s3_reg;
	logic [arfr_pkg::RES_W-1:0] cres_s1_reg;
	logic [arfr_pkg::RES_W-1:0] cres_s2_reg;
	logic [31:0]                rdata_next;
	arfr_pkg::arfr_state_t      state_reg;
	arfr_pkg::arfr_state_t      state_next;

	// APB decode; the slave answers in the access cycle with no wait.
	wire        acc      = psel & penable;
	wire        wr       = acc & pwrite;
	wire        hit_c0   = paddr == arfr_pkg::OFS_CTRL0;
	wire        hit_c1   = paddr == arfr_pkg::OFS_CTRL1;
	wire        hit_c2   = paddr == arfr_pkg::OFS_CTRL2;
	wire        hit_hi   = paddr == arfr_pkg::OFS_RES_HIGH;
	wire        hit_lo   = paddr == arfr_pkg::OFS_RES_LOW;
	wire        hit_st   = paddr == arfr_pkg::OFS_IRQ_STAT;
	wire        hit_mk   = paddr == arfr_pkg::OFS_IRQ_MASK;
	wire        hit_aq   = paddr == arfr_pkg::OFS_ACQ_CNT;
	wire        mapped   = hit_c0 | hit_c1 | hit_c2 | hit_hi | hit_lo | hit_st | hit_mk | hit_aq;
	wire [7:0]  wbyte    = pwdata[7:0];
	wire        wr_c0    = wr & hit_c0;
	wire        trig_rise = trig_s2_reg & ~trig_s3_reg;
	wire        sw_go    = wr_c0 & wbyte[arfr_pkg::BIT_GO] & ~ctrl0_reg[arfr_pkg::BIT_GO];
	wire        hw_go    = trig_rise & (ctrl2_reg[7:4] != 4'h0);
	wire        chs_chg  = wr_c0 &
		(wbyte[arfr_pkg::CHS_LSB +: arfr_pkg::CHS_W] != ctrl0_reg[arfr_pkg::CHS_LSB +: arfr_pkg::CHS_W]);
	wire        idle     = state_reg == arfr_pkg::ARFR_IDLE;
	// Starts are taken only while idle, so a trigger edge mid-conversion is ignored.
	wire        go_start = (sw_go | hw_go) & ctrl0_reg[arfr_pkg::BIT_ON] & idle;
	wire        conv_end = (state_reg == arfr_pkg::ARFR_CONV) && (cnt_reg == 16'(CONV_CYCLES - 1));
	wire        go_drop  = (state_reg == arfr_pkg::ARFR_CONV) && (state_next == arfr_pkg::ARFR_IDLE);
	// A start with too little acquisition time is flagged, not blocked; a start
	// written together with a new channel has had no acquisition time at all.
	wire        early    = go_start & (chs_chg | (acq_reg < 16'(CONV_CYCLES)));
	wire [arfr_pkg::IRQ_W-1:0] ev = {early, conv_end};
	wire [arfr_pkg::IRQ_W-1:0] clr = (wr & hit_st) ? wbyte[arfr_pkg::IRQ_W-1:0] : '0;

	assign res.load       = load_reg;
	assign res.value      = res_reg;
	assign res.justify    = ctrl1_reg[arfr_pkg::BIT_JUSTIFY];
	assign res.sw_wr_high = ce & wr & hit_hi;
	assign res.sw_wr_low  = ce & wr & hit_lo;
	assign res.sw_data    = wbyte;

	arfr_result_store u_store (
		.pclk (pclk),
		.ce   (ce),
		.res  (res)
	);

	// Sequencer: idle until go, then count conversion cycles.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			arfr_pkg::ARFR_IDLE: begin
				cnt_next = '0;
				if (go_start) state_next = arfr_pkg::ARFR_CONV;
			end
			arfr_pkg::ARFR_CONV: begin
				cnt_next = cnt_reg + 16'h0001;
				if (conv_end || !ctrl0_reg[arfr_pkg::BIT_ON]) state_next = arfr_pkg::ARFR_IDLE;
			end
			default: state_next = arfr_pkg::ARFR_IDLE;
		endcase
	end

	// Acquisition counter restarts on channel change, saturates at the top.
	assign acq_next = chs_chg ? 16'h0000 : (&acq_reg ? acq_reg : acq_reg + 16'h0001);

	// Software writes every control 0 field except go, which only the sequencer
	// moves; otherwise a go written while the converter is off would stick high.
	always_comb begin
		ctrl0_wr                   = wbyte & arfr_pkg::CTRL0_MASK;
		ctrl0_wr[arfr_pkg::BIT_GO] = ctrl0_reg[arfr_pkg::BIT_GO];
	end

	// Read mux; unmapped addresses read zero with an error.
	always_comb begin
		rdata_next = '0;
		if (hit_c0) rdata_next[7:0] = ctrl0_reg;
		if (hit_c1) rdata_next[7:0] = ctrl1_reg;
		if (hit_c2) rdata_next[7:0] = ctrl2_reg;
		if (hit_hi) rdata_next[7:0] = res.high_byte;
		if (hit_lo) rdata_next[7:0] = res.low_byte;
		if (hit_st) rdata_next[arfr_pkg::IRQ_W-1:0] = stat_reg;
		if (hit_mk) rdata_next[arfr_pkg::IRQ_W-1:0] = mask_reg;
		if (hit_aq) rdata_next[15:0] = acq_reg;
	end

	// Trigger pin passes two flops before use; the third only delays for the edge.
	// Its reset value matches the idle pin level, so no false edge follows reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else if (ce) begin
			trig_s1_reg <= auto_trigger;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	// The result word passes two flops too; the core holds it steady while a
	// conversion runs, so the word has settled long before it is captured.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cres_s1_reg <= '0;
			cres_s2_reg <= '0;
		end else if (ce) begin
			cres_s1_reg <= conversion_result;
			cres_s2_reg <= cres_s1_reg;
		end
	end

	// Control register 0; go rises with a start and falls as the sequencer leaves.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_reg <= 8'h00;
		end else if (ce) begin
			if (wr_c0) ctrl0_reg <= ctrl0_wr;
			if (go_start) ctrl0_reg[arfr_pkg::BIT_GO] <= 1'b1;
			if (go_drop) ctrl0_reg[arfr_pkg::BIT_GO] <= 1'b0;
		end
	end

	// Control registers 1 and 2 and the interrupt mask; unused bits stay zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_reg <= 8'h00;
			ctrl2_reg <= 8'h00;
			mask_reg  <= '0;
		end else if (ce) begin
			if (wr & hit_c1) ctrl1_reg <= wbyte & arfr_pkg::CTRL1_MASK;
			if (wr & hit_c2) ctrl2_reg <= wbyte & arfr_pkg::CTRL2_MASK;
			if (wr & hit_mk) mask_reg <= wbyte[arfr_pkg::IRQ_W-1:0];
		end
	end

	// Sequencer state and its cycle counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= arfr_pkg::ARFR_IDLE;
			cnt_reg   <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Acquisition counter, counting since the last channel change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_reg <= arfr_pkg::ACQ_CNT_RESET;
		end else if (ce) begin
			acq_reg <= acq_next;
		end
	end

	// Result capture; the load pulse trails the end by one edge so both bytes
	// move together, and software polling go sees them one cycle later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_reg <= 1'b0;
			res_reg  <= '0;
		end else if (ce) begin
			load_reg <= conv_end;
			if (conv_end) res_reg <= cres_s2_reg;
		end
	end

	// Sticky status; a new event beats a clear in the same cycle, so no event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '0;
		end else if (ce) begin
			stat_reg <= (stat_reg & ~clr) | ev;
		end
	end

	// Bus answer, registered; the access cycle always completes without wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= rdata_next;
		end
	end

	// Pin outputs, registered; the interrupt lags its status by one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_on      <= 1'b0;
			input_channel_sel <= '0;
			irq               <= 1'b0;
		end else if (ce) begin
			converter_on      <= ctrl0_reg[arfr_pkg::BIT_ON];
			input_channel_sel <= ctrl0_reg[arfr_pkg::CHS_LSB +: arfr_pkg::CHS_W];
			irq               <= |(stat_reg & mask_reg);
		end
	end
endmodule : arfr_top
`default_nettype wire

/* sim/arfr_assertions.sv */
// Purpose: Port checks for the result formatting block.
// Assumes: One clock; the bench holds ce high.
// Notes: Bound to arfr_top below.
`timescale 1ns/1ps
`default_nettype none
module arfr_assertions (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [arfr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        converter_on,
	input wire logic [arfr_pkg::CHS_W-1:0]  input_channel_sel
);
	// A finished write to control register 0 is the only cause for its copies to move.
	wire wr0 = psel && penable && pready && pwrite && paddr == 12'h000;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready too long");
	ready_in_access_a: assert property (psel && penable && $past(psel) |-> pready)
		else $error("no pready in access");
	ready_needs_sel_a: assert property (!psel |-> !pready) else $error("pready unselected");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
	unmapped_err_a: assert property (pready && paddr > 12'h01c |-> pslverr)
		else $error("unmapped without pslverr");
	mapped_ok_a: assert property (pready && paddr <= 12'h01c && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped with pslverr");
	byte_upper_zero_a: assert property (pready && !pwrite && paddr <= 12'h010 |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	on_follows_a: assert property ($changed(converter_on) |-> $past(wr0) || $past(wr0, 2))
		else $error("converter_on moved alone");
	chan_follows_a: assert property ($changed(input_channel_sel) |-> $past(wr0) || $past(wr0, 2))
		else $error("channel moved alone");
endmodule : arfr_assertions
bind arfr_top arfr_assertions chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .converter_on, .input_channel_sel);
`default_nettype wire

/* sim/arfr_top_tb.sv */
// Purpose: Directed checks of result formatting, registers and interrupt.
// Assumes: ce held high; auto trigger driven only in trig_seq; the bench plays the analog core.
// Notes: Each scenario task drives the bus and judges its own reads.
`timescale 1ns/1ps
`default_nettype none
module arfr_top_tb;
	logic        pclk, presetn, ce, psel, penable, pwrite, auto_trigger, pready, pslverr, err;
	logic        converter_on, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  conversion_result;
	logic [4:0]  input_channel_sel;
	int          failures, samples_checked;
	arfr_top uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .conversion_result, .auto_trigger, .converter_on, .input_channel_sel, .irq);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One APB transfer; an edge passes first so strobes never toggle twice in a step.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Stale ones are written first so the zero fill after a load is visible.
	task automatic conv(input logic just, input logic [9:0] v, input logic [7:0] eh, el);
		int n;
		conversion_result <= v;
		apb(1, arfr_pkg::OFS_RES_HIGH, 32'hff);
		apb(1, arfr_pkg::OFS_RES_LOW, 32'hff);
		apb(1, arfr_pkg::OFS_CTRL1, {24'h0, just, 7'h0});
		apb(1, arfr_pkg::OFS_CTRL0, 32'h9);
		repeat (20) @(posedge pclk);
		check("channel out", 32'h2, {27'h0, input_channel_sel});
		check("on out", 32'h1, {31'h0, converter_on});
		apb(1, arfr_pkg::OFS_CTRL0, 32'hb);
		apb(0, arfr_pkg::OFS_CTRL0, 0);
		check("go set", 32'hb, rd);
		n = 0;
		while (rd[1] !== 1'b0 && n < 40) begin
			apb(0, arfr_pkg::OFS_CTRL0, 0);
			n++;
		end
		check("go cleared", 32'h9, rd);
		apb(0, arfr_pkg::OFS_RES_HIGH, 0);
		check("high byte", {24'h0, eh}, rd);
		apb(0, arfr_pkg::OFS_RES_LOW, 0);
		check("low byte", {24'h0, el}, rd);
	endtask : conv
	task automatic irq_seq();
		apb(0, arfr_pkg::OFS_IRQ_STAT, 0);
		check("done flag", 32'h1, rd);
		apb(1, arfr_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		check("irq on", 32'h1, {31'h0, irq});
		apb(1, arfr_pkg::OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		check("irq masked", 32'h0, {31'h0, irq});
		apb(1, arfr_pkg::OFS_IRQ_STAT, 32'h1);
		apb(0, arfr_pkg::OFS_IRQ_STAT, 0);
		check("flag cleared", 32'h0, rd);
		apb(1, arfr_pkg::OFS_CTRL0, 32'hf);
		apb(0, arfr_pkg::OFS_IRQ_STAT, 0);
		check("early go flag", 32'h2, rd);
		repeat (30) @(posedge pclk);
		apb(0, 12'h100, 0);
		check("unmapped data", 32'h0, rd);
		check("unmapped err", 32'h1, {31'h0, err});
	endtask : irq_seq
	// A trigger edge with a source selected starts a conversion without software.
	task automatic trig_seq();
		apb(1, arfr_pkg::OFS_CTRL2, 32'h30);
		auto_trigger <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(0, arfr_pkg::OFS_CTRL0, 0);
		check("trigger go", 32'hf, rd);
		repeat (30) @(posedge pclk);
		apb(0, arfr_pkg::OFS_CTRL0, 0);
		check("trigger done", 32'hd, rd);
		auto_trigger <= 1'b0;
		apb(1, arfr_pkg::OFS_CTRL2, 32'h0);
	endtask : trig_seq
	// Result bytes must survive a reset that is not a power-on.
	task automatic keep_reset();
		apb(1, arfr_pkg::OFS_RES_HIGH, 32'h5a);
		apb(1, arfr_pkg::OFS_RES_LOW, 32'ha5);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		check("on after reset", 32'h0, {31'h0, converter_on});
		apb(0, arfr_pkg::OFS_RES_HIGH, 0);
		check("high kept", 32'h5a, rd);
		apb(0, arfr_pkg::OFS_RES_LOW, 0);
		check("low kept", 32'ha5, rd);
	endtask : keep_reset
	task automatic test_done();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		{presetn, psel, penable, pwrite, auto_trigger} = 5'h0;
		ce = 1'b1;
		paddr = 12'h0;
		pwdata = 32'h0;
		conversion_result = 10'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		conv(1'b1, 10'h2b5, 8'h02, 8'hb5);
		conv(1'b0, 10'h1ce, 8'h73, 8'h80);
		irq_seq();
		trig_seq();
		keep_reset();
		test_done();
	end
	// The whole run needs well under 2000 cycles.
	initial begin
		#100us;
		failures++;
		test_done();
	end
endmodule : arfr_top_tb
`default_nettype wire
